// >>> inc/lbm_pkg.sv
/*
  Constants for the bit-load and memory-load execution unit: opcodes,
  cycle counts, instruction field positions and the execution states.
  Assumes an 8-bit core with 16 working registers and a 16-bit memory space.
*/
package lbm_pkg;
  localparam logic [7:0] OPC_LOAD_BIT   = 8'h47;
  localparam logic [7:0] OPC_IND_LOAD   = 8'hc3;
  localparam logic [7:0] OPC_IND_STORE  = 8'hd3;
  localparam logic [7:0] OPC_XS_LOAD    = 8'he7;
  localparam logic [7:0] OPC_XS_STORE   = 8'hf7;
  localparam logic [7:0] OPC_XL_LOAD    = 8'ha7;
  localparam logic [7:0] OPC_XL_STORE   = 8'hb7;
  localparam logic [3:0] PAIR_DIRECT_PM = 4'h0;
  localparam logic [3:0] PAIR_DIRECT_DM = 4'h1;
  localparam logic [3:0] CYC_LOAD_BIT   = 4'h6;
  localparam logic [3:0] CYC_IND        = 4'ha;
  localparam logic [3:0] CYC_XS         = 4'hc;
  localparam logic [3:0] CYC_XL         = 4'he;
  localparam logic [3:0] CYC_ACCESS_AT  = 4'h4;
  localparam int         DIR_BIT        = 0;
  localparam int         BIDX_LSB       = 1;
  localparam int         BIDX_MSB       = 3;
  localparam int         HI_LSB         = 4;
  localparam int         HI_MSB         = 7;
  typedef enum logic [3:0] {
    LBM_IDLE   = 4'h1,
    LBM_FETCH  = 4'h2,
    LBM_EXEC   = 4'h4,
    LBM_FINISH = 4'h8
  } lbm_state_e;
endpackage : lbm_pkg

// >>> core/lbm_addr_gen.sv
/*
  Effective address generator for the memory loads.
  Assumes the pair value and displacement are stable while selected.
*/
`timescale 1ns/1ns
module lbm_addr_gen
  import lbm_pkg::*;
(
  input  wire logic [15:0] pair_value,
  input  wire logic [15:0] displacement,
  input  wire logic        direct,
  output logic      [15:0] eff_addr
);
  wire logic [15:0] indexed_addr;
  // Plain 16-bit add so the sum wraps; pair itself is only read
  assign indexed_addr = pair_value + displacement;
  assign eff_addr     = direct ? displacement : indexed_addr;
endmodule : lbm_addr_gen

// >>> core/lbm_exec.sv
/*
  Execution unit for bit load and memory load instructions.
  Assumes the core presents one instruction byte per fetch handshake and
  that memories return read data one cycle after a read strobe.
*/
`timescale 1ns/1ns
module lbm_exec
  import lbm_pkg::*;
#(
  parameter bit MASK_ROM = 1'b0
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand_byte,
  input  wire logic        operand_valid,
  output logic             operand_req,
  output logic [3:0]       wreg_addr,
  input  wire logic [7:0]  wreg_rdata,
  output logic             wreg_we,
  output logic [7:0]       wreg_wdata,
  output logic [3:0]       pair_addr,
  input  wire logic [15:0] pair_rdata,
  output logic [7:0]       greg_addr,
  input  wire logic [7:0]  greg_rdata,
  output logic             greg_we,
  output logic [7:0]       greg_wdata,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             pm_rd,
  output logic             pm_wr,
  output logic             dm_rd,
  output logic             dm_wr,
  input  wire logic [7:0]  pm_rdata,
  input  wire logic [7:0]  dm_rdata,
  output logic             flags_we,
  output logic             busy,
  output logic             done,
  output logic             illegal
);
  lbm_state_e       state;
  lbm_state_e       next_state;
  logic [7:0]       op;
  logic [7:0]       byte2;
  logic [7:0]       byte3;
  logic [7:0]       byte4;
  logic [1:0]       fetched;
  logic [3:0]       cycle;
  logic             is_read;
  logic [15:0]      eff_addr;

  wire logic        op_bit     = (op == OPC_LOAD_BIT);
  wire logic        op_ind     = (op == OPC_IND_LOAD) || (op == OPC_IND_STORE);
  wire logic        op_xs      = (op == OPC_XS_LOAD) || (op == OPC_XS_STORE);
  wire logic        op_xl      = (op == OPC_XL_LOAD) || (op == OPC_XL_STORE);
  wire logic        op_store   = (op == OPC_IND_STORE) || (op == OPC_XS_STORE)
                                 || (op == OPC_XL_STORE);
  wire logic [3:0]  pair_fld   = byte2[HI_LSB-4 +: 4];
  // Pair 0-1 in the long form means direct address, never an index
  wire logic        direct     = op_xl && (pair_fld == PAIR_DIRECT_PM
                                 || pair_fld == PAIR_DIRECT_DM);
  // Even pair field or direct 0000 selects program memory
  wire logic        to_data    = pair_fld[0];
  wire logic [1:0]  need_bytes = op_bit ? 2'd2 : op_ind ? 2'd1 : op_xs ? 2'd2 : 2'd3;
  wire logic [3:0]  total_cyc  = op_bit ? CYC_LOAD_BIT : op_ind ? CYC_IND
                                 : op_xs ? CYC_XS : CYC_XL;
  wire logic        supported  = (op_bit || op_ind || op_xs || op_xl)
                                 && !(MASK_ROM && !op_bit);
  wire logic [15:0] disp       = op_xl ? {byte4, byte3} : op_xs ? {8'h00, byte3}
                                 : 16'h0000;
  wire logic        last_cyc   = (cycle == total_cyc - 4'h1);
  wire logic        access_cyc = (state == LBM_EXEC) && (cycle == CYC_ACCESS_AT);
  wire logic [2:0]  bidx       = byte2[BIDX_MSB:BIDX_LSB];
  wire logic        bit_store  = byte2[DIR_BIT];
  wire logic        bit_src    = bit_store ? wreg_rdata[0] : greg_rdata[bidx];
  wire logic [7:0]  bit_result;

  lbm_addr_gen lbm_addr_gen_i (
    .pair_value   (pair_rdata),
    .displacement (disp),
    .direct       (direct),
    .eff_addr     (eff_addr)
  );

  // Bit insert: only one destination bit changes
  for (genvar i = 0; i < 8; i++) begin : g_bit_ins
    wire logic hit_store = bit_store && (bidx == 3'(i));
    wire logic hit_load  = !bit_store && (i == 0);
    assign bit_result[i] = (hit_store || hit_load) ? bit_src
                           : bit_store ? greg_rdata[i] : wreg_rdata[i];
  end

  always_comb begin
    next_state = state;
    case (state)
      LBM_IDLE:   if (start) next_state = LBM_FETCH;
      LBM_FETCH:  if (!supported) next_state = LBM_FINISH;
                  else if (operand_valid && fetched == need_bytes - 2'd1)
                    next_state = LBM_EXEC;
      LBM_EXEC:   if (last_cyc) next_state = LBM_FINISH;
      LBM_FINISH: next_state = LBM_IDLE;
      default:    next_state = LBM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) state <= LBM_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op <= 8'h00;
      byte2 <= 8'h00;
      byte3 <= 8'h00;
      byte4 <= 8'h00;
      fetched <= 2'd0;
    end else if (state == LBM_IDLE && start) begin
      op <= opcode;
      fetched <= 2'd0;
    end else if (state == LBM_FETCH && operand_valid) begin
      case (fetched)
        2'd0:    byte2 <= operand_byte;
        2'd1:    byte3 <= operand_byte;
        default: byte4 <= operand_byte;
      endcase
      fetched <= fetched + 2'd1;
    end
  end

  // Cycle count from start, one cycle spent in the start state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cycle <= 4'h0;
    else if (state == LBM_IDLE) cycle <= 4'h1;
    else if (state != LBM_FINISH) cycle <= cycle + 4'h1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) is_read <= 1'b0;
    // Memory data stands only in the cycle after the read strobe
    else is_read <= pm_rd || dm_rd;
  end

  // Strobe decode, registered below so each strobe is a clean pulse
  wire logic go_mem     = access_cyc && !op_bit;
  wire logic next_pm_rd = go_mem && !op_store && !to_data;
  wire logic next_dm_rd = go_mem && !op_store && to_data;
  wire logic next_pm_wr = go_mem && op_store && !to_data;
  wire logic next_dm_wr = go_mem && op_store && to_data;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pm_rd <= 1'b0;
      pm_wr <= 1'b0;
      dm_rd <= 1'b0;
      dm_wr <= 1'b0;
    end else begin
      pm_rd <= next_pm_rd;
      dm_rd <= next_dm_rd;
      pm_wr <= next_pm_wr;
      dm_wr <= next_dm_wr;
    end
  end

  // Address and store data hold until the next access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr  <= 16'h0000;
      mem_wdata <= 8'h00;
    end else if (access_cyc) begin
      mem_addr  <= eff_addr;
      mem_wdata <= wreg_rdata;
    end
  end

  // Cycles spent executing; a missed count end would otherwise go unseen
  logic [4:0]       exec_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) exec_cnt <= 5'h00;
    else if (state != LBM_EXEC) exec_cnt <= 5'h00;
    else if (exec_cnt != 5'h1f) exec_cnt <= exec_cnt + 5'h01;
  end

  // Working, pair and general register ports, operand request and status outputs
  assign wreg_addr  = byte2[HI_MSB:HI_LSB];
  assign pair_addr  = pair_fld;
  assign greg_addr  = byte3;
  assign operand_req = (state == LBM_FETCH) && supported;
  wire logic read_ret = is_read && cycle == CYC_ACCESS_AT + 4'h2;
  assign wreg_we    = (state == LBM_EXEC) && (op_bit ? (last_cyc && !bit_store)
                      : read_ret);
  assign wreg_wdata = op_bit ? bit_result : (to_data ? dm_rdata : pm_rdata);
  assign greg_we    = (state == LBM_EXEC) && op_bit && last_cyc && bit_store;
  assign greg_wdata = bit_result;
  assign flags_we   = 1'b0;
  assign busy       = (state != LBM_IDLE);
  assign done       = (state == LBM_FINISH);
  assign illegal    = (state == LBM_FETCH) && !supported;

  // Flags and lengths
  AST_NO_FLAGS: assert property (
    @(posedge clk) disable iff (!reset_n)
    !flags_we
  ) else $error("flags written");
  AST_BIT_LEN: assert property (
    @(posedge clk) disable iff (!reset_n)
    (greg_we || (wreg_we && op_bit)) |-> cycle == CYC_LOAD_BIT - 4'h1
  ) else $error("bit load length wrong");
  AST_BIT_NO_MEM: assert property (
    @(posedge clk) disable iff (!reset_n)
    (busy && op_bit) |-> !(pm_rd || pm_wr || dm_rd || dm_wr)
  ) else $error("bit load touched memory");
  AST_BIT_ONE_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    greg_we |-> !wreg_we
  ) else $error("bit load wrote both registers");
  AST_EXEC_BOUND: assert property (
    @(posedge clk) disable iff (!reset_n)
    exec_cnt <= 5'(CYC_XL)
  ) else $error("execution ran too long");
  AST_DONE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state == LBM_EXEC && last_cyc) |=> done
  ) else $error("no finish");
  AST_DONE_PULSE: assert property (
    @(posedge clk) disable iff (!reset_n)
    done |=> !done
  ) else $error("done held too long");

  // Bus selection and strobes
  AST_PM_SEL: assert property (
    @(posedge clk) disable iff (!reset_n)
    (pm_rd || pm_wr) |-> !dm_rd && !dm_wr
  ) else $error("two buses at once");
  AST_ONE_STROBE: assert property (
    @(posedge clk) disable iff (!reset_n)
    $onehot0({pm_rd, pm_wr, dm_rd, dm_wr})
  ) else $error("more than one strobe");
  AST_STROBE_ONCE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (pm_rd || pm_wr || dm_rd || dm_wr) |=> !(pm_rd || pm_wr || dm_rd || dm_wr)
  ) else $error("strobe longer than one cycle");
  AST_EVEN_PM: assert property (
    @(posedge clk) disable iff (!reset_n)
    access_cyc && !op_bit && !pair_fld[0] |=> (pm_rd || pm_wr)
  ) else $error("even pair missed program memory");
  AST_ODD_DM: assert property (
    @(posedge clk) disable iff (!reset_n)
    access_cyc && !op_bit && pair_fld[0] |=> (dm_rd || dm_wr)
  ) else $error("odd pair missed data memory");
  AST_DIRECT_PM: assert property (
    @(posedge clk) disable iff (!reset_n)
    access_cyc && direct && pair_fld == PAIR_DIRECT_PM |=> (pm_rd || pm_wr)
  ) else $error("direct 0000 missed program memory");
  AST_DIRECT_DM: assert property (
    @(posedge clk) disable iff (!reset_n)
    access_cyc && direct && pair_fld == PAIR_DIRECT_DM |=> (dm_rd || dm_wr)
  ) else $error("direct 0001 missed data memory");

  // Addresses and data
  AST_IND_ADDR: assert property (
    @(posedge clk) disable iff (!reset_n)
    access_cyc && op_ind |=> mem_addr == $past(pair_rdata)
  ) else $error("indirect address wrong");
  AST_XS_ADDR: assert property (
    @(posedge clk) disable iff (!reset_n)
    access_cyc && op_xs |=> mem_addr == $past(pair_rdata + {8'h00, byte3})
  ) else $error("short indexed address wrong");
  AST_ADDR: assert property (
    @(posedge clk) disable iff (!reset_n)
    access_cyc && op_xl && !direct |=> mem_addr == $past(pair_rdata + {byte4, byte3})
  ) else $error("indexed address wrong");
  AST_DIRECT: assert property (
    @(posedge clk) disable iff (!reset_n)
    access_cyc && direct |=> mem_addr == $past({byte4, byte3})
  ) else $error("direct address wrong");
  AST_STORE_DATA: assert property (
    @(posedge clk) disable iff (!reset_n)
    (access_cyc && op_store) |=> mem_wdata == $past(wreg_rdata)
  ) else $error("store data wrong");
  AST_LOAD_WB: assert property (
    @(posedge clk) disable iff (!reset_n)
    (access_cyc && !op_bit && !op_store) |-> ##2 wreg_we
  ) else $error("load data not written back");
  AST_WB_AFTER_READ: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wreg_we && !op_bit) |-> $past(pm_rd || dm_rd)
  ) else $error("register written without read data");
  AST_STORE_NO_WB: assert property (
    @(posedge clk) disable iff (!reset_n)
    (busy && op_store) |-> !wreg_we
  ) else $error("store changed its source");

  // Refused instructions
  AST_ROM: assert property (
    @(posedge clk) disable iff (!reset_n)
    MASK_ROM |-> !(pm_rd || dm_rd || pm_wr || dm_wr)
  ) else $error("rom part used memory");
  AST_ILL_DONE: assert property (
    @(posedge clk) disable iff (!reset_n)
    illegal |=> done
  ) else $error("refused op did not finish");
  AST_ILL_NO_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (busy && !supported) |-> !wreg_we && !greg_we
  ) else $error("refused op wrote a register");

  COV_BIT: cover property (@(posedge clk) greg_we);
  COV_PM_RD: cover property (@(posedge clk) pm_rd);
  COV_DM_WR: cover property (@(posedge clk) dm_wr);
  COV_ILL: cover property (@(posedge clk) illegal);
  COV_DIRECT: cover property (@(posedge clk) access_cyc && direct);
endmodule : lbm_exec

// >>> verification/lbm_mem_model.sv
/*
  Program and data memory model for the bit and memory load unit.
  Assumes strobes are one-cycle pulses and read data is taken a cycle later.
*/
`timescale 1ns/1ns
module lbm_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        pm_rd,
  input  wire logic        pm_wr,
  input  wire logic        dm_rd,
  input  wire logic        dm_wr,
  output logic      [7:0]  pm_rdata,
  output logic      [7:0]  dm_rdata
);
  logic [7:0] pm [0:65535];
  logic [7:0] dm [0:65535];
  initial begin
    pm_rdata = 8'h00;
    dm_rdata = 8'h00;
    for (int a = 0; a < 65536; a++) begin
      pm[a] = 8'(a) ^ 8'h3c;
      dm[a] = 8'(a) ^ 8'hc3;
    end
  end
  // Data valid one cycle only, scrambled after so stale reads show
  always @(posedge clk) begin
    pm_rdata <= pm_rd ? pm[mem_addr] : ~pm_rdata;
    dm_rdata <= dm_rd ? dm[mem_addr] : ~dm_rdata;
    if (pm_wr) pm[mem_addr] <= mem_wdata;
    if (dm_wr) dm[mem_addr] <= mem_wdata;
  end
endmodule : lbm_mem_model

// >>> verification/load_bit_and_memory_instr_tb_top.sv
/*
  Self-checking bench for the bit and memory load unit.
  Assumes lbm_pkg and lbm_mem_model are compiled first.
*/
`timescale 1ns/1ns
module load_bit_and_memory_instr_tb_top;
  import lbm_pkg::*;
  logic        clk, reset_n, start, operand_valid;
  logic [7:0]  opcode, operand_byte;
  logic [15:0] pair_val;
  logic [7:0]  wf [0:15];
  logic [7:0]  gf [0:255];
  wire         operand_req, wreg_we, greg_we, pm_rd, pm_wr, dm_rd, dm_wr;
  wire         flags_we, busy, done, illegal;
  wire  [3:0]  wreg_addr, pair_addr;
  wire  [7:0]  wreg_rdata, greg_rdata, pm_rdata, dm_rdata;
  wire  [7:0]  wreg_wdata, greg_addr, greg_wdata, mem_wdata;
  wire  [15:0] mem_addr;
  int          n_mismatch, num_checks, cyc, flag_hits, ill_hits;
  assign wreg_rdata = wf[wreg_addr];
  assign greg_rdata = gf[greg_addr];
  lbm_exec lbm_exec_i (.clk, .reset_n, .start, .opcode, .operand_byte, .operand_valid,
    .operand_req, .wreg_addr, .wreg_rdata, .wreg_we, .wreg_wdata, .pair_addr,
    .pair_rdata(pair_val), .greg_addr, .greg_rdata, .greg_we, .greg_wdata, .mem_addr,
    .mem_wdata, .pm_rd, .pm_wr, .dm_rd, .dm_wr, .pm_rdata, .dm_rdata, .flags_we,
    .busy, .done, .illegal);
  lbm_mem_model lbm_mem_model_i (.clk, .mem_addr, .mem_wdata, .pm_rd, .pm_wr, .dm_rd,
    .dm_wr, .pm_rdata, .dm_rdata);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Register file writes land here, so checks see what the unit wrote
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wreg_we) wf[wreg_addr] <= wreg_wdata;
    if (greg_we) gf[greg_addr] <= greg_wdata;
    if (flags_we) flag_hits <= flag_hits + 1;
    if (illegal) ill_hits <= ill_hits + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_cyc(input int took, input int lim);
    num_checks++;
    if (took > lim) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: took %0d cycles, limit %0d", $time, took, lim);
    end
  endtask : chk_cyc
  task automatic run(input logic [7:0] op, b2, b3, b4, input int nb);
    int t0;
    int w;
    int lim;
    lim = nb == 2 ? CYC_IND : nb == 4 ? CYC_XL : op == OPC_LOAD_BIT ? CYC_LOAD_BIT : CYC_XS;
    start = 1'b1;
    opcode = op;
    t0 = cyc;
    @(negedge clk);
    start = 1'b0;
    for (int k = 1; k < nb; k++) begin
      w = 0;
      while (operand_req !== 1'b1 && w < 50) begin
        @(negedge clk);
        w++;
      end
      operand_byte = k == 1 ? b2 : k == 2 ? b3 : b4;
      operand_valid = 1'b1;
      @(negedge clk);
    end
    operand_valid = 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 100) begin
      @(negedge clk);
      w++;
    end
    chk(8'(busy), 8'h01);
    chk_cyc(cyc - t0, lim + 1);
    @(negedge clk);
  endtask : run
  // Loads expect the bus pattern; stores expect the byte on one bus only
  task automatic memop(input logic [7:0] op, b2, b3, b4, input int nb, input logic [15:0] a);
    logic [3:0] r;
    logic       dmb;
    logic [7:0] keep;
    r = b2[7:4];
    dmb = b2[0];
    keep = dmb ? lbm_mem_model_i.pm[a] : lbm_mem_model_i.dm[a];
    wf[r] = 8'h11 ^ a[7:0];
    run(op, b2, b3, b4, nb);
    chk(8'(pair_addr), 8'(b2[3:0]));
    if (op[4]) begin
      chk(dmb ? lbm_mem_model_i.dm[a] : lbm_mem_model_i.pm[a], 8'h11 ^ a[7:0]);
      chk(dmb ? lbm_mem_model_i.pm[a] : lbm_mem_model_i.dm[a], keep);
      chk(wf[r], 8'h11 ^ a[7:0]);
    end
    else chk(wf[r], a[7:0] ^ (dmb ? 8'hc3 : 8'h3c));
  endtask : memop
  task automatic t_bit_load();
    wf[0] = 8'h06;
    gf[0] = 8'h05;
    run(OPC_LOAD_BIT, 8'h04, 8'h00, 8'h00, 3);
    chk(wf[0], 8'h07);
    chk(gf[0], 8'h05);
    wf[0] = 8'h06;
    run(OPC_LOAD_BIT, 8'h01, 8'h00, 8'h00, 3);
    chk(gf[0], 8'h04);
    chk(wf[0], 8'h06);
    wf[6] = 8'hff;
    gf[8'h81] = 8'h00;
    run(OPC_LOAD_BIT, 8'h6f, 8'h81, 8'h00, 3);
    chk(gf[8'h81], 8'h80);
    $display("Test bit_load finished");
  endtask : t_bit_load
  task automatic t_indirect();
    pair_val = 16'h0104;
    memop(OPC_IND_LOAD, 8'h02, 8'h00, 8'h00, 2, 16'h0104);
    memop(OPC_IND_LOAD, 8'h13, 8'h00, 8'h00, 2, 16'h0104);
    memop(OPC_IND_STORE, 8'h22, 8'h00, 8'h00, 2, 16'h0104);
    memop(OPC_IND_STORE, 8'h23, 8'h00, 8'h00, 2, 16'h0104);
    $display("Test indirect finished");
  endtask : t_indirect
  task automatic t_short();
    memop(OPC_XS_LOAD, 8'h42, 8'h01, 8'h00, 3, 16'h0105);
    memop(OPC_XS_LOAD, 8'h53, 8'h01, 8'h00, 3, 16'h0105);
    memop(OPC_XS_STORE, 8'h62, 8'h01, 8'h00, 3, 16'h0105);
    memop(OPC_XS_STORE, 8'h73, 8'h01, 8'h00, 3, 16'h0105);
    $display("Test short_displacement finished");
  endtask : t_short
  task automatic t_long();
    memop(OPC_XL_LOAD, 8'h82, 8'h00, 8'h10, 4, 16'h1104);
    memop(OPC_XL_LOAD, 8'h93, 8'h00, 8'h10, 4, 16'h1104);
    pair_val = 16'hffff;
    memop(OPC_XL_STORE, 8'ha4, 8'h02, 8'h00, 4, 16'h0001);
    memop(OPC_XL_STORE, 8'hb5, 8'h02, 8'h00, 4, 16'h0001);
    $display("Test long_displacement finished");
  endtask : t_long
  task automatic t_direct();
    pair_val = 16'h5555;
    memop(OPC_XL_LOAD, 8'hc0, 8'h00, 8'h22, 4, 16'h2200);
    memop(OPC_XL_LOAD, 8'hd1, 8'h00, 8'h22, 4, 16'h2200);
    memop(OPC_XL_STORE, 8'he0, 8'h00, 8'h23, 4, 16'h2300);
    memop(OPC_XL_STORE, 8'hf1, 8'h00, 8'h23, 4, 16'h2300);
    $display("Test direct_address finished");
  endtask : t_direct
  initial begin
    {start, operand_valid, opcode, operand_byte, pair_val} = '0;
    {n_mismatch, num_checks, cyc, flag_hits, ill_hits} = '0;
    reset_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    t_bit_load();
    t_indirect();
    t_short();
    t_long();
    t_direct();
    chk(8'(ill_hits), 8'h00);
    run(8'h00, 8'h00, 8'h00, 8'h00, 1);
    chk(8'(ill_hits != 0), 8'h01);
    chk(8'(flag_hits), 8'h00);
    final_report();
  end
endmodule : load_bit_and_memory_instr_tb_top
